// *** rtl/leaf_entry_pkg.sv ***
package leaf_entry_pkg;
   // register byte offsets on the 32-bit Avalon-MM slave
   localparam logic [4:0] OFF_ENTRY_LO = 5'h00;
   localparam logic [4:0] OFF_ENTRY_HI = 5'h04;
   localparam logic [4:0] OFF_CTRL     = 5'h08;
   localparam logic [4:0] OFF_STATUS   = 5'h0C;
   localparam logic [4:0] OFF_BASE_LO  = 5'h10;
   localparam logic [4:0] OFF_BASE_HI  = 5'h14;
   localparam logic [4:0] OFF_RESULT   = 5'h18;
   localparam logic [4:0] OFF_DENIES   = 5'h1C;

   // entry field positions
   localparam int ENTRY_W        = 64;
   localparam int BIT_READ       = 0;
   localparam int BIT_WRITE      = 1;
   localparam int BIT_EXEC       = 2;
   localparam int MT_LSB         = 3;
   localparam int MT_W           = 3;
   localparam int BIT_IGN_TABLE  = 6;
   localparam int BIT_LARGE_PAGE = 7;
   localparam int BIT_SNOOP      = 11;
   localparam int TABLE_LSB      = 12;
   localparam int PAGE_LSB       = 21;
   localparam int RSVD_TOP       = 51;

   // control register bits
   localparam int CTRL_MT_OVR    = 0;
   localparam int CTRL_EXEC_EN   = 1;
   localparam int CTRL_SNOOP_SUP = 2;
   localparam int CTRL_ZLR_SUP   = 3;
   localparam int CTRL_W         = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

   // status register bits
   localparam int ST_LEAF      = 0;
   localparam int ST_RSVD_ERR  = 1;
   localparam int ST_MT_DEF    = 2;
   localparam int ST_READ      = 3;
   localparam int ST_WRITE     = 4;
   localparam int ST_EXEC      = 5;
   localparam int ST_SNOOP     = 6;
   localparam int ST_IGN_TABLE = 7;
   localparam int ST_MT_LSB    = 8;

   // result register bits (last request answered)
   localparam int RS_ALLOW     = 0;
   localparam int RS_SNOOP     = 1;
   localparam int RS_NFIELD    = 2;
   localparam int RS_USE_TABLE = 3;
   localparam int RS_MT_VALID  = 4;

   // memory type encodings
   localparam logic [MT_W-1:0] MT_UC = 3'h0;
   localparam logic [MT_W-1:0] MT_WC = 3'h1;
   localparam logic [MT_W-1:0] MT_WT = 3'h4;
   localparam logic [MT_W-1:0] MT_WP = 3'h5;
   localparam logic [MT_W-1:0] MT_WB = 3'h6;

   // only five encodings name a memory type; the rest are reserved
   function automatic logic mt_defined(input logic [MT_W-1:0] mt);
      return (mt == MT_UC) || (mt == MT_WC) || (mt == MT_WT) || (mt == MT_WP) || (mt == MT_WB);
   endfunction : mt_defined
endpackage : leaf_entry_pkg

// *** rtl/entry_field_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module entry_field_decoder
   import leaf_entry_pkg::*;
#(
   parameter int HOST_ADDRESS_WIDTH = 48
) (
   input  wire logic [ENTRY_W-1:0]            entry,
   input  wire logic                          snoop_control_support,
   output logic                               large_page_flag,
   output logic                               rsvd_err,
   output logic [HOST_ADDRESS_WIDTH-1:0]      base,
   output logic                               read_bit,
   output logic                               write_bit,
   output logic                               exec_bit,
   output logic                               force_snoop,
   output logic                               ignore_attribute_table,
   output logic [MT_W-1:0]                    memory_type_field,
   output logic                               mt_is_defined
);
   // field extraction and reserved-bit scan
   always_comb begin
      logic upper_rsvd;
      logic mid_rsvd;
      upper_rsvd = 1'b0;
      mid_rsvd   = 1'b0;
      for (int i = HOST_ADDRESS_WIDTH; i <= RSVD_TOP; i++) begin
         upper_rsvd = upper_rsvd | entry[i];
      end
      for (int i = TABLE_LSB; i < PAGE_LSB; i++) begin
         mid_rsvd = mid_rsvd | entry[i];
      end
      large_page_flag = entry[BIT_LARGE_PAGE];
      base = '0;
      if (large_page_flag) begin
         base[HOST_ADDRESS_WIDTH-1:PAGE_LSB] = entry[HOST_ADDRESS_WIDTH-1:PAGE_LSB];
      end else begin
         base[HOST_ADDRESS_WIDTH-1:TABLE_LSB] = entry[HOST_ADDRESS_WIDTH-1:TABLE_LSB]; // next table
      end
      // snoop bit is a must-be-zero bit without snoop control
      force_snoop = snoop_control_support & entry[BIT_SNOOP];
      rsvd_err = upper_rsvd
               | (large_page_flag & mid_rsvd)
               | (large_page_flag & ~snoop_control_support & entry[BIT_SNOOP]);
      read_bit  = entry[BIT_READ];
      write_bit = entry[BIT_WRITE];
      exec_bit  = entry[BIT_EXEC];
      ignore_attribute_table = entry[BIT_IGN_TABLE];
      memory_type_field = entry[MT_LSB +: MT_W];
      mt_is_defined = mt_defined(memory_type_field);
   end
endmodule : entry_field_decoder
`default_nettype wire

// *** rtl/access_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module access_checker
   import leaf_entry_pkg::*;
(
   input  wire logic            large_page_flag,
   input  wire logic            rsvd_err,
   input  wire logic            read_bit,
   input  wire logic            write_bit,
   input  wire logic            exec_bit,
   input  wire logic            force_snoop,
   input  wire logic            ignore_attribute_table,
   input  wire logic            mt_is_defined,
   input  wire logic            memory_type_override_enable,
   input  wire logic            second_level_execute_enable,
   input  wire logic            zero_length_read_support,
   input  wire logic            req_translation,
   input  wire logic            req_pasid,
   input  wire logic            req_nested_coherent,
   input  wire logic            req_read,
   input  wire logic            req_write,
   input  wire logic            req_exec,
   input  wire logic            req_zero_length,
   input  wire logic            no_snoop_attr,
   output logic                 read_ok,
   output logic                 write_ok,
   output logic                 exec_ok,
   output logic                 allow,
   output logic                 snoop,
   output logic                 n_field,
   output logic                 use_attr_table,
   output logic                 mt_valid
);
   // permission checks; a denied kind only matters if the request asks for it
   always_comb begin
      logic zlr_skip;
      logic mt_applies;
      zlr_skip = zero_length_read_support & req_zero_length & (write_bit | exec_bit);
      read_ok  = read_bit | zlr_skip;
      write_ok = write_bit;
      exec_ok  = exec_bit | ~second_level_execute_enable;
      allow = large_page_flag & ~rsvd_err
            & (~req_read | read_ok)
            & (~req_write | write_ok)
            & (~req_exec | exec_ok);
      // snoop override only counts without pasid
      if (req_pasid) begin
         snoop   = 1'b1;
         n_field = 1'b1;
      end else begin
         snoop   = force_snoop | ~no_snoop_attr;
         n_field = force_snoop;
      end
      // attribute-table bypass only for nested pasid traffic under override
      mt_applies = memory_type_override_enable & req_pasid & req_nested_coherent;
      use_attr_table = ~(mt_applies & ignore_attribute_table);
      mt_valid = memory_type_override_enable & mt_is_defined;
      // snoop matters for untranslated traffic, the n field only for translation completions
      if (req_translation) begin
         snoop   = 1'b0;
      end else begin
         n_field = 1'b0;
      end
   end
endmodule : access_checker
`default_nettype wire

// *** rtl/two_mb_leaf_entry_decoder.sv ***
// Notes on behaviour
// - a leaf entry gives the host physical page base from entry bits host_address_width-1 down to 21.
// - without snoop control support, bit 11 is a must-be-zero reserved bit, not a snoop override.
// - untranslated requests without pasid snoop whenever force_snoop is 1, whatever their no-snoop attribute.
// - translation requests without pasid return force_snoop as the completion's non-snooped field.
// - requests with pasid ignore force_snoop, and untranslated ones always snoop.
// - translation requests with pasid always return the non-snooped field as one.
// - the entry is a 2-MByte leaf only when bit 7 is 1, otherwise it points to a next-level table.
// - under memory type override, nested pasid requests from coherent devices use the attribute table when bit 6 is 0.
// - under memory type override, bits 5:3 give the memory type, and are ignored otherwise.
// - memory type codes other than 0h, 1h, 4h, 5h and 6h are reserved, never a valid type.
// - with second-level execute enabled, execute is denied when bit 2 is 0.
// - write is denied when bit 1 is 0.
// - read is denied when bit 0 is 0.
// - with zero-length-read support, zero-length reads skip the read check when bit 1 or bit 2 is 1.
`timescale 1ns/1ps
`default_nettype none
module two_mb_leaf_entry_decoder
   import leaf_entry_pkg::*;
#(
   parameter int HOST_ADDRESS_WIDTH = 48,
   parameter int DENY_CNT_W         = 16
) (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // avalon-mm slave
   input  wire logic [4:0]                    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic [31:0]                        avs_readdata,
   output logic                               avs_waitrequest,
   // table walker
   input  wire logic                          walk_valid,
   input  wire logic [ENTRY_W-1:0]            walk_entry,
   output logic                               walk_done,
   output logic                               walk_leaf,
   output logic                               walk_rsvd_err,
   output logic [HOST_ADDRESS_WIDTH-1:0]      walk_base,
   // dma request pipeline
   input  wire logic                          req_valid,
   input  wire logic                          req_translation,
   input  wire logic                          req_pasid,
   input  wire logic                          req_nested_coherent,
   input  wire logic                          req_read,
   input  wire logic                          req_write,
   input  wire logic                          req_exec,
   input  wire logic                          req_zero_length,
   input  wire logic                          no_snoop_attr,
   output logic                               resp_valid,
   output logic                               resp_allow,
   output logic                               resp_snoop,
   output logic                               resp_n_field,
   output logic                               resp_use_attr_table,
   output logic                               resp_mt_valid,
   output logic [MT_W-1:0]                    resp_memory_type
);
   logic [ENTRY_W-1:0]               entry_q;
   logic [CTRL_W-1:0]                ctrl_q;
   logic                             load_q;
   logic                             walk_done_q;
   logic                             rd_ack_q;
   logic [31:0]                      rdata_q;
   logic [DENY_CNT_W-1:0]            deny_cnt_q;

   // decoded entry, registered so walker and status see flop outputs
   logic                             leaf_d, leaf_q;
   logic                             rsvd_d, rsvd_q;
   logic [HOST_ADDRESS_WIDTH-1:0]    base_d, base_q;
   logic                             rd_bit_d, rd_bit_q;
   logic                             wr_bit_d, wr_bit_q;
   logic                             ex_bit_d, ex_bit_q;
   logic                             fsnp_d, fsnp_q;
   logic                             ignt_d, ignt_q;
   logic [MT_W-1:0]                  mt_d, mt_q;
   logic                             mtdef_d, mtdef_q;

   logic                             read_ok, write_ok, exec_ok;
   logic                             allow_c, snoop_c, nfield_c, usetab_c, mtval_c;
   logic                             wr_hit;
   logic [63:0]                      base_w;

   // resp registers
   logic                             resp_valid_q, resp_allow_q, resp_snoop_q, resp_n_q;
   logic                             resp_usetab_q, resp_mtval_q;
   logic [MT_W-1:0]                  resp_mt_q;

   entry_field_decoder #(
      .HOST_ADDRESS_WIDTH (HOST_ADDRESS_WIDTH)
   ) u_dec (
      .entry                  (entry_q),
      .snoop_control_support  (ctrl_q[CTRL_SNOOP_SUP]),
      .large_page_flag        (leaf_d),
      .rsvd_err               (rsvd_d),
      .base                   (base_d),
      .read_bit               (rd_bit_d),
      .write_bit              (wr_bit_d),
      .exec_bit               (ex_bit_d),
      .force_snoop            (fsnp_d),
      .ignore_attribute_table (ignt_d),
      .memory_type_field      (mt_d),
      .mt_is_defined          (mtdef_d)
   );

   access_checker u_chk (
      .large_page_flag             (leaf_q),
      .rsvd_err                    (rsvd_q),
      .read_bit                    (rd_bit_q),
      .write_bit                   (wr_bit_q),
      .exec_bit                    (ex_bit_q),
      .force_snoop                 (fsnp_q),
      .ignore_attribute_table      (ignt_q),
      .mt_is_defined               (mtdef_q),
      .memory_type_override_enable (ctrl_q[CTRL_MT_OVR]),
      .second_level_execute_enable (ctrl_q[CTRL_EXEC_EN]),
      .zero_length_read_support    (ctrl_q[CTRL_ZLR_SUP]),
      .req_translation             (req_translation),
      .req_pasid                   (req_pasid),
      .req_nested_coherent         (req_nested_coherent),
      .req_read                    (req_read),
      .req_write                   (req_write),
      .req_exec                    (req_exec),
      .req_zero_length             (req_zero_length),
      .no_snoop_attr               (no_snoop_attr),
      .read_ok                     (read_ok),
      .write_ok                    (write_ok),
      .exec_ok                     (exec_ok),
      .allow                       (allow_c),
      .snoop                       (snoop_c),
      .n_field                     (nfield_c),
      .use_attr_table              (usetab_c),
      .mt_valid                    (mtval_c)
   );

   // writes finish in their first cycle; reads wait one cycle for registered data
   assign wr_hit          = avs_write & ~avs_read;
   assign avs_waitrequest = avs_read & ~rd_ack_q;
   assign avs_readdata    = rdata_q;

   // byte-lane merge for writable words
   function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   // entry holder: walker load takes priority over a software write in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         entry_q <= '0;
      end else if (walk_valid) begin
         entry_q <= walk_entry;
      end else if (wr_hit && avs_address == OFF_ENTRY_LO) begin
         entry_q[31:0] <= merge_be(entry_q[31:0], avs_writedata, avs_byteenable);
      end else if (wr_hit && avs_address == OFF_ENTRY_HI) begin
         entry_q[63:32] <= merge_be(entry_q[63:32], avs_writedata, avs_byteenable);
      end
   end

   // context and capability controls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_hit && avs_address == OFF_CTRL && avs_byteenable[0]) begin
         ctrl_q <= avs_writedata[CTRL_W-1:0];
      end
   end

   // decode stage register, refreshed every cycle from the held entry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         leaf_q   <= 1'b0;
         rsvd_q   <= 1'b0;
         base_q   <= '0;
         rd_bit_q <= 1'b0;
         wr_bit_q <= 1'b0;
         ex_bit_q <= 1'b0;
         fsnp_q   <= 1'b0;
         ignt_q   <= 1'b0;
         mt_q     <= MT_UC;
         mtdef_q  <= 1'b0;
      end else begin
         leaf_q   <= leaf_d;
         rsvd_q   <= rsvd_d;
         base_q   <= base_d;
         rd_bit_q <= rd_bit_d;
         wr_bit_q <= wr_bit_d;
         ex_bit_q <= ex_bit_d;
         fsnp_q   <= fsnp_d;
         ignt_q   <= ignt_d;
         mt_q     <= mt_d;
         mtdef_q  <= mtdef_d;
      end
   end

   // walker answer two edges after walk_valid: entry edge, then decode edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load_q      <= 1'b0;
         walk_done_q <= 1'b0;
      end else begin
         load_q      <= walk_valid;
         walk_done_q <= load_q;
      end
   end

   assign walk_done     = walk_done_q;
   assign walk_leaf     = leaf_q;
   assign walk_rsvd_err = rsvd_q;
   assign walk_base     = base_q;

   // request answer one edge after req_valid, checked against the decoded entry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid_q  <= 1'b0;
         resp_allow_q  <= 1'b0;
         resp_snoop_q  <= 1'b0;
         resp_n_q      <= 1'b0;
         resp_usetab_q <= 1'b1;
         resp_mtval_q  <= 1'b0;
         resp_mt_q     <= MT_UC;
      end else begin
         resp_valid_q <= req_valid;
         if (req_valid) begin
            resp_allow_q  <= allow_c;
            resp_snoop_q  <= ~req_translation & snoop_c;
            resp_n_q      <= req_translation & nfield_c;
            resp_usetab_q <= usetab_c;
            resp_mtval_q  <= mtval_c;
            resp_mt_q     <= ctrl_q[CTRL_MT_OVR] ? mt_q : MT_UC;    // field ignored without override
         end
      end
   end

   assign resp_valid          = resp_valid_q;
   assign resp_allow          = resp_allow_q;
   assign resp_snoop          = resp_snoop_q;
   assign resp_n_field        = resp_n_q;
   assign resp_use_attr_table = resp_usetab_q;
   assign resp_mt_valid       = resp_mtval_q;
   assign resp_memory_type    = resp_mt_q;

   // denial counter saturates so software never sees a wrap as few denials
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deny_cnt_q <= '0;
      end else if (wr_hit && avs_address == OFF_DENIES) begin
         deny_cnt_q <= '0;
      end else if (req_valid && !allow_c && deny_cnt_q != '1) begin
         deny_cnt_q <= deny_cnt_q + 1'b1;
      end
   end

   assign base_w = 64'(base_q);

   // read data register and one-cycle read acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ack_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         rd_ack_q <= avs_read & ~rd_ack_q;
         if (avs_read && !rd_ack_q) begin
            rdata_q <= 32'h0000_0000;                               // unmapped reads return zero
            unique case (avs_address)
               OFF_ENTRY_LO: rdata_q <= entry_q[31:0];
               OFF_ENTRY_HI: rdata_q <= entry_q[63:32];
               OFF_CTRL:     rdata_q[CTRL_W-1:0] <= ctrl_q;
               OFF_STATUS: begin
                  rdata_q[ST_LEAF]      <= leaf_q;
                  rdata_q[ST_RSVD_ERR]  <= rsvd_q;
                  rdata_q[ST_MT_DEF]    <= mtdef_q;
                  rdata_q[ST_READ]      <= read_ok;
                  rdata_q[ST_WRITE]     <= write_ok;
                  rdata_q[ST_EXEC]      <= exec_ok;
                  rdata_q[ST_SNOOP]     <= fsnp_q;
                  rdata_q[ST_IGN_TABLE] <= ignt_q;
                  rdata_q[ST_MT_LSB +: MT_W] <= mt_q;
               end
               OFF_BASE_LO:  rdata_q <= base_w[31:0];
               OFF_BASE_HI:  rdata_q <= base_w[63:32];
               OFF_RESULT: begin
                  rdata_q[RS_ALLOW]     <= resp_allow_q;
                  rdata_q[RS_SNOOP]     <= resp_snoop_q;
                  rdata_q[RS_NFIELD]    <= resp_n_q;
                  rdata_q[RS_USE_TABLE] <= resp_usetab_q;
                  rdata_q[RS_MT_VALID]  <= resp_mtval_q;
               end
               OFF_DENIES:   rdata_q[DENY_CNT_W-1:0] <= deny_cnt_q;
               default:      rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule : two_mb_leaf_entry_decoder
`default_nettype wire

// *** tb/leaf_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module leaf_sva (
   input wire logic clk, rst_n, avs_read, avs_write, avs_waitrequest, walk_valid, walk_done,
   input wire logic walk_leaf, walk_rsvd_err, req_valid, req_translation, req_pasid, no_snoop_attr,
   input wire logic resp_valid, resp_allow, resp_snoop, resp_n_field
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a read stalls exactly one cycle, then its data stand
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   sequence s_plain_req;
      req_valid && !req_pasid && !req_translation;
   endsequence
   chk_read_one_wait: assert property ($rose(avs_read) |-> s_one_wait) else $error("read wait");
   chk_write_no_wait: assert property (avs_write && !avs_read |-> !avs_waitrequest) else $error("write wait");
   chk_walk_done_lat: assert property (walk_valid |-> ##2 walk_done) else $error("walk late");
   chk_resp_next_cycle: assert property (req_valid |=> resp_valid) else $error("resp late");
   chk_plain_snoop: assert property ((s_plain_req and !no_snoop_attr) |=> resp_snoop) else $error("snoop");
   chk_pasid_snoop: assert property (req_valid && req_pasid && !req_translation |=> resp_snoop) else $error("pasid snoop");
   chk_pasid_nfield: assert property (req_valid && req_pasid && req_translation |=> resp_n_field) else $error("n field");
   chk_bad_entry_deny: assert property (req_valid && (!walk_leaf || walk_rsvd_err) |=> !resp_allow) else $error("allowed");
endmodule : leaf_sva
`default_nettype wire

// *** tb/walk_dma_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// walker and dma source; idle lines show the inverse of the last value so stale data never looks fresh
module walk_dma_model
   import leaf_entry_pkg::*;
(
   input  wire logic          clk,
   output logic               walk_valid,
   output logic [ENTRY_W-1:0] walk_entry,
   output logic               req_valid,
   output logic [7:0]         req_bits
);
   initial begin
      walk_valid = 1'b0;
      walk_entry = '0;
      req_valid = 1'b0;
      req_bits = '0;
   end
   // walk_done stands in the cycle after the decode edge; look 1 ns after that edge
   task automatic load(input logic [ENTRY_W-1:0] e);
      @(posedge clk);
      walk_valid <= 1'b1;
      walk_entry <= e;
      @(posedge clk);
      walk_valid <= 1'b0;
      walk_entry <= ~e;
      @(posedge clk);
      #1;
   endtask : load
   // bits: translation, pasid, nested coherent, read, write, exec, zero length, no snoop
   task automatic ask(input logic [7:0] b);
      @(posedge clk);
      req_valid <= 1'b1;
      req_bits <= b;
      @(posedge clk);
      req_valid <= 1'b0;
      req_bits <= ~b;
      #1;
   endtask : ask
endmodule : walk_dma_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import leaf_entry_pkg::*;
;
   localparam logic [63:0] E1 = 64'h0000_00AB_CDE0_08F3;
   logic clk, avs_waitrequest, walk_done, walk_leaf, walk_rsvd_err, resp_valid, resp_allow, resp_snoop;
   logic resp_n_field, resp_use_attr_table, resp_mt_valid, walk_valid, req_valid;
   logic rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [3:0] avs_byteenable = 4'hF;
   logic [2:0] resp_memory_type;
   logic [39:0] walk_base;
   logic [63:0] walk_entry;
   logic [7:0] req_bits;
   logic req_translation, req_pasid, req_nested_coherent, req_read, req_write, req_exec, req_zero_length, no_snoop_attr;
   int miscompares = 0, comparisons = 0;
   assign {req_translation, req_pasid, req_nested_coherent, req_read, req_write, req_exec, req_zero_length,
           no_snoop_attr} = req_bits;
   two_mb_leaf_entry_decoder #(.HOST_ADDRESS_WIDTH(40)) DUT (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .walk_valid, .walk_entry, .walk_done,
      .walk_leaf, .walk_rsvd_err, .walk_base, .req_valid, .req_translation, .req_pasid, .req_nested_coherent,
      .req_read, .req_write, .req_exec, .req_zero_length, .no_snoop_attr, .resp_valid, .resp_allow, .resp_snoop,
      .resp_n_field, .resp_use_attr_table, .resp_mt_valid, .resp_memory_type);
   walk_dma_model u_model (.clk, .walk_valid, .walk_entry, .req_valid, .req_bits);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      // waitrequest is looked at on the rising edge, before that edge's updates land
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic walk(input logic [63:0] en, input logic [1:0] e);
      u_model.load(en);
      check("walk", {walk_done, walk_leaf, walk_rsvd_err}, {1'b1, e});
   endtask : walk
   // expected: allow, snoop, n field, use table, type valid, memory type
   task automatic req(input logic [7:0] b, input logic [7:0] e);
      u_model.ask(b);
      check("resp", {resp_valid, resp_allow, resp_snoop, resp_n_field, resp_use_attr_table, resp_mt_valid,
                     resp_memory_type}, {1'b1, e});
   endtask : req
   task automatic end_sim;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (2000) @(posedge clk);
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, OFF_CTRL, 32'h0);
      check("ctrl_reset", rd, 32'h0);
      bus(1'b1, OFF_CTRL, 32'hF);
      bus(1'b0, OFF_CTRL, 32'h0);
      check("ctrl", rd, 32'hF);
      $display("test registers done");
      walk(E1, 2'b10);
      check("base", walk_base, 40'hAB_CDE0_0000);
      req(8'h11, 8'hDE);
      req(8'h90, 8'hBE);
      req(8'h04, 8'h5E);
      req(8'hE8, 8'hAE);
      req(8'h71, 8'hCE);
      walk(64'h94, 2'b10);
      req(8'h13, 8'h92);
      req(8'h11, 8'h12);
      req(8'h09, 8'h12);
      $display("test full control done");
      bus(1'b1, OFF_CTRL, 32'h0);
      walk(E1, 2'b11);
      req(8'h11, 8'h10);
      walk(64'h0000_2000_0000_0081, 2'b11);
      walk(64'h1001, 2'b00);
      req(8'h11, 8'h10);
      walk(64'h81, 2'b10);
      req(8'h05, 8'h90);
      bus(1'b0, OFF_RESULT, 32'h0);
      check("result", rd, 32'h9);
      bus(1'b0, OFF_DENIES, 32'h0);
      check("denies", rd, 32'h5);
      $display("test reduced control done");
      end_sim();
   end
endmodule : tb_top
bind two_mb_leaf_entry_decoder leaf_sva u_sva (.clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .walk_valid,
   .walk_done, .walk_leaf, .walk_rsvd_err, .req_valid, .req_translation, .req_pasid, .no_snoop_attr, .resp_valid,
   .resp_allow, .resp_snoop, .resp_n_field);
`default_nettype wire
